// [hdl/cou_compare_unit.v]
// Operation
// - Scalar equality compares both 32-bit operands as signed values and yields 1 when equal.
// - Signed greater-or-equal yields 1 when the first signed operand is not below the second.
// - Unsigned greater-or-equal zero-extends an immediate second operand and yields 1 when first >= second.
// - Signed greater-than yields 1 only when the first signed operand strictly exceeds the second.
// - A condition result may feed a conditional jump only 2 cycles after its compare issues.
// - Apart from jumps, a condition result is readable by any following operation at once.
// - Packed byte equality to a condition register puts lane j's flag in condition bit j.
// - Packed byte equality to a general register writes 1 or 0 into each byte lane.
// - Packed half equality to a condition register copies lane j's flag into bits 2j and 2j+1.
// - Packed half equality to a general register writes 1 or 0 into each 16-bit half.
// - Float equality treats operands as single precision with the unit's own equality function.
// - Float greater-or-equal yields 1 when the first single precision value is >= the second.
// - Compares have no placement limits and never raise an exception for any operands.
`timescale 1ns/1ps
`include "cou_defines.vh"

module cou_compare_unit #(
  parameter IMM_W   = `COU_IMM_W,
  parameter DEST_W  = `COU_DEST_W,
  parameter JUMP_LAT = `COU_CR_JUMP_LAT
) (
  input  wire                    i_clock,
  input  wire                    i_reset,
  input  wire                    i_issue,
  input  wire [`COU_OP_W-1:0]    i_opcode,
  input  wire                    i_dest_is_condition,
  input  wire                    i_use_immediate,
  input  wire [DEST_W-1:0]       i_dest_index,
  input  wire [`COU_DATA_W-1:0]  i_first_operand,
  input  wire [`COU_DATA_W-1:0]  i_second_operand,
  input  wire [IMM_W-1:0]        i_immediate_second_operand,
  output reg                     o_result_valid,
  output reg  [DEST_W-1:0]       o_dest_index,
  output reg                     o_general_write,
  output reg  [`COU_DATA_W-1:0]  o_general_result,
  output reg                     o_condition_write,
  output reg  [`COU_CR_W-1:0]    o_condition_result,
  output reg                     o_jump_hold
);

  // ----------------------------------------
  // Immediate extension
  // ----------------------------------------
  function [`COU_DATA_W-1:0] cou_extend;
    input [IMM_W-1:0] value;
    input             signed_form;
    begin
      cou_extend = {{(`COU_DATA_W-IMM_W){signed_form & value[IMM_W-1]}}, value};
    end
  endfunction

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  wire                   signed_form;
  wire                   packed_or_float;
  wire [`COU_DATA_W-1:0] second_value;

  assign signed_form     = (i_opcode != `COU_OP_GEU);
  // Packed and float forms have no immediate variant
  assign packed_or_float = (i_opcode == `COU_OP_PB_EQ) || (i_opcode == `COU_OP_PH_EQ) ||
                           (i_opcode == `COU_OP_FEQ)   || (i_opcode == `COU_OP_FGE);
  assign second_value    = (i_use_immediate && !packed_or_float) ?
                           cou_extend(i_immediate_second_operand, signed_form) :
                           i_second_operand;

  // ----------------------------------------
  // Scalar compares
  // ----------------------------------------
  wire scalar_equal;
  wire signed_ge;
  wire unsigned_ge;
  wire signed_gt;

  assign scalar_equal = (i_first_operand == second_value);
  assign signed_ge    = ($signed(i_first_operand) >= $signed(second_value));
  assign unsigned_ge  = (i_first_operand >= second_value);
  assign signed_gt    = ($signed(i_first_operand) > $signed(second_value));

  // ----------------------------------------
  // Packed lane compares
  // ----------------------------------------
  reg [3:0] byte_equal;
  reg [1:0] half_equal;
  integer   byte_lane;
  integer   half_lane;

  always @* begin
    byte_equal = 4'h0;
    for (byte_lane = 0; byte_lane < 4; byte_lane = byte_lane + 1) begin
      byte_equal[byte_lane] = (i_first_operand[byte_lane*8 +: 8] ==
                               i_second_operand[byte_lane*8 +: 8]);
    end
  end

  always @* begin
    half_equal = 2'h0;
    for (half_lane = 0; half_lane < 2; half_lane = half_lane + 1) begin
      half_equal[half_lane] = (i_first_operand[half_lane*16 +: 16] ==
                               i_second_operand[half_lane*16 +: 16]);
    end
  end

  // ----------------------------------------
  // Float compares
  // ----------------------------------------
  wire float_equal;
  wire float_ge;

  cou_fp_compare u_fp_compare (
    .i_first         (i_first_operand),
    .i_second        (i_second_operand),
    .o_equal         (float_equal),
    .o_greater_equal (float_ge)
  );

  // ----------------------------------------
  // Result shaping
  // ----------------------------------------
  reg                   scalar_flag;
  reg                   lane_form;
  reg [`COU_DATA_W-1:0] lane_general;
  reg [`COU_CR_W-1:0]   lane_condition;

  // unknown codes give 0, never a trap
  always @* begin
    scalar_flag    = 1'b0;
    lane_form      = 1'b0;
    lane_general   = 32'h00000000;
    lane_condition = 4'h0;
    case (i_opcode)
      `COU_OP_EQ: begin
        scalar_flag = scalar_equal;
      end
      `COU_OP_GE: begin
        scalar_flag = signed_ge;
      end
      `COU_OP_GEU: begin
        scalar_flag = unsigned_ge;
      end
      `COU_OP_GT: begin
        scalar_flag = signed_gt;
      end
      `COU_OP_PB_EQ: begin
        lane_form      = 1'b1;
        // value 1 in each equal byte
        lane_general   = {7'h00, byte_equal[3], 7'h00, byte_equal[2],
                          7'h00, byte_equal[1], 7'h00, byte_equal[0]};
        // lane j to condition bit j
        lane_condition = byte_equal;
      end
      `COU_OP_PH_EQ: begin
        lane_form      = 1'b1;
        // value 1 in each equal half
        lane_general   = {15'h0000, half_equal[1], 15'h0000, half_equal[0]};
        // lane j to bits 2j and 2j+1
        lane_condition = {half_equal[1], half_equal[1], half_equal[0], half_equal[0]};
      end
      `COU_OP_FEQ: begin
        scalar_flag = float_equal;
      end
      `COU_OP_FGE: begin
        scalar_flag = float_ge;
      end
      default: begin
        scalar_flag = 1'b0;
      end
    endcase
  end

  wire [`COU_DATA_W-1:0] next_general_result;
  wire [`COU_CR_W-1:0]   next_condition_result;

  // scalar flag in bit 0, upper bits clear
  assign next_general_result   = lane_form ? lane_general : {31'h00000000, scalar_flag};
  assign next_condition_result = lane_form ? lane_condition : {3'h0, scalar_flag};

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  // condition value visible the cycle after issue
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_result_valid     <= 1'b0;
      o_dest_index       <= {DEST_W{1'b0}};
      o_general_write    <= 1'b0;
      o_general_result   <= 32'h00000000;
      o_condition_write  <= 1'b0;
      o_condition_result <= 4'h0;
    end else begin
      o_result_valid    <= i_issue;
      o_general_write   <= i_issue & !i_dest_is_condition;
      o_condition_write <= i_issue & i_dest_is_condition;
      if (i_issue) begin
        o_dest_index <= i_dest_index;
        if (i_dest_is_condition) begin
          o_condition_result <= next_condition_result;
        end else begin
          o_general_result <= next_general_result;
        end
      end
    end
  end

  // ----------------------------------------
  // Conditional jump interlock
  // ----------------------------------------
  // Counts down the cycles a new condition is still unfit for a jump
  reg [`COU_CNT_W-1:0] jump_wait;
  reg [`COU_CNT_W-1:0] next_jump_wait;

  // hold jumps until 2 cycles after issue
  always @* begin
    if (i_issue && i_dest_is_condition) begin
      next_jump_wait = JUMP_LAT[`COU_CNT_W-1:0] - 2'h1;
    end else if (jump_wait != 2'h0) begin
      next_jump_wait = jump_wait - 2'h1;
    end else begin
      next_jump_wait = 2'h0;
    end
  end

  // Issue cycle itself is covered by the pipeline; hold covers the gap after it
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      jump_wait   <= 2'h0;
      o_jump_hold <= 1'b0;
    end else begin
      jump_wait   <= next_jump_wait;
      o_jump_hold <= (next_jump_wait != 2'h0);
    end
  end

endmodule // cou_compare_unit

// [hdl/cou_defines.vh]
`ifndef COU_DEFINES_VH
`define COU_DEFINES_VH

// ----------------------------------------
// Compare operation codes
// ----------------------------------------
`define COU_OP_W         4
`define COU_OP_EQ        4'h0
`define COU_OP_GE        4'h1
`define COU_OP_GEU       4'h2
`define COU_OP_GT        4'h3
`define COU_OP_PB_EQ     4'h4
`define COU_OP_PH_EQ     4'h5
`define COU_OP_FEQ       4'h6
`define COU_OP_FGE       4'h7

// ----------------------------------------
// Widths and lanes
// ----------------------------------------
`define COU_DATA_W       32
`define COU_IMM_W        9
`define COU_CR_W         4
`define COU_DEST_W       6

// ----------------------------------------
// Single precision field positions
// ----------------------------------------
`define COU_FP_SIGN      31
`define COU_FP_EXP_HI    30
`define COU_FP_EXP_LO    23
`define COU_FP_MAN_HI    22
`define COU_FP_EXP_ONES  8'hff

// ----------------------------------------
// Timing counts in cycles
// ----------------------------------------
`define COU_CR_JUMP_LAT  2
`define COU_CNT_W        2

`endif

// [hdl/cou_fp_compare.v]
`timescale 1ns/1ps
`include "cou_defines.vh"

// ----------------------------------------
// Single precision equal and greater-or-equal
// ----------------------------------------
module cou_fp_compare (
  input  wire [31:0] i_first,
  input  wire [31:0] i_second,
  output reg         o_equal,
  output reg         o_greater_equal
);

  wire nan_first;
  wire nan_second;
  wire both_zero;
  wire any_nan;

  // NaN never compares true; signed zeros are equal
  assign nan_first  = (i_first[`COU_FP_EXP_HI:`COU_FP_EXP_LO] == `COU_FP_EXP_ONES) &&
                      (i_first[`COU_FP_MAN_HI:0] != 23'h000000);
  assign nan_second = (i_second[`COU_FP_EXP_HI:`COU_FP_EXP_LO] == `COU_FP_EXP_ONES) &&
                      (i_second[`COU_FP_MAN_HI:0] != 23'h000000);
  assign any_nan    = nan_first | nan_second;
  assign both_zero  = (i_first[30:0] == 31'h00000000) && (i_second[30:0] == 31'h00000000);

  always @* begin
    o_equal = !any_nan && ((i_first == i_second) || both_zero);
  end

  // float greater or equal, sign-magnitude order
  always @* begin
    if (any_nan) begin
      o_greater_equal = 1'b0;
    end else if (both_zero) begin
      o_greater_equal = 1'b1;
    end else if (i_first[`COU_FP_SIGN] != i_second[`COU_FP_SIGN]) begin
      o_greater_equal = !i_first[`COU_FP_SIGN];
    end else if (!i_first[`COU_FP_SIGN]) begin
      o_greater_equal = (i_first[30:0] >= i_second[30:0]);
    end else begin
      o_greater_equal = (i_first[30:0] <= i_second[30:0]);
    end
  end

endmodule // cou_fp_compare

// [testbench/cou_chk.sv]
`timescale 1ns/1ps
`include "cou_defines.vh"
module cou_chk #(
  parameter IMM_W    = 9,
  parameter DEST_W   = 6,
  parameter JUMP_LAT = 2
) (
  input wire              i_clock,
  input wire              i_reset,
  input wire              i_issue,
  input wire [3:0]        i_opcode,
  input wire              i_dest_is_condition,
  input wire              i_use_immediate,
  input wire [DEST_W-1:0] i_dest_index,
  input wire [31:0]       i_first_operand,
  input wire [31:0]       i_second_operand,
  input wire [IMM_W-1:0]  i_immediate_second_operand,
  input wire              o_result_valid,
  input wire [DEST_W-1:0] o_dest_index,
  input wire              o_general_write,
  input wire [31:0]       o_general_result,
  input wire              o_condition_write,
  input wire [3:0]        o_condition_result,
  input wire              o_jump_hold
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  wire cnd_iss = i_issue && i_dest_is_condition;
  wire gen_iss = i_issue && !i_dest_is_condition;
  valid_lat_a: assert property (i_issue |=> o_result_valid)
    else $error("valid missing after issue");
  quiet_idle_a: assert property (!i_issue |=>
    !o_result_valid && !o_general_write && !o_condition_write)
    else $error("strobe without issue");
  gen_strobe_a: assert property (gen_iss |=> o_general_write && !o_condition_write
    && o_dest_index == $past(i_dest_index)) else $error("general write wrong");
  cnd_strobe_a: assert property (cnd_iss |=> o_condition_write && !o_general_write)
    else $error("condition write wrong");
  jump_hold_a: assert property (cnd_iss |=> o_jump_hold ##1 (o_jump_hold == $past(cnd_iss)))
    else $error("jump hold wrong");
  scalar_top_a: assert property (gen_iss && i_opcode < 4 |=> o_general_result[31:1] == 31'h0)
    else $error("upper bits set");
  eq_value_a: assert property (gen_iss && i_opcode == `COU_OP_EQ && !i_use_immediate
    |=> o_general_result[0] == $past(i_first_operand == i_second_operand)) else $error("eq bad");
  gt_value_a: assert property (gen_iss && i_opcode == `COU_OP_GT && !i_use_immediate |=>
    o_general_result[0] == $past($signed(i_first_operand) > $signed(i_second_operand)))
    else $error("gt bad");
  pb_lane_a: assert property (cnd_iss && i_opcode == `COU_OP_PB_EQ |=>
    o_condition_result[0] == $past(i_first_operand[7:0] == i_second_operand[7:0]))
    else $error("byte lane bad");
  ph_pair_a: assert property (cnd_iss && i_opcode == `COU_OP_PH_EQ |=>
    o_condition_result[1] == o_condition_result[0] && o_condition_result[3] == o_condition_result[2])
    else $error("half pair bad");
  cover property (cnd_iss ##1 cnd_iss);
  cover property (gen_iss && i_opcode == `COU_OP_FGE);
  cover property (i_issue && i_use_immediate && i_opcode == `COU_OP_GEU);
endmodule // cou_chk

bind cou_compare_unit cou_chk #(.IMM_W(IMM_W), .DEST_W(DEST_W), .JUMP_LAT(JUMP_LAT)) u_chk (
  .i_clock(i_clock), .i_reset(i_reset), .i_issue(i_issue), .i_opcode(i_opcode),
  .i_dest_is_condition(i_dest_is_condition), .i_use_immediate(i_use_immediate),
  .i_dest_index(i_dest_index), .i_first_operand(i_first_operand),
  .i_second_operand(i_second_operand), .i_immediate_second_operand(i_immediate_second_operand),
  .o_result_valid(o_result_valid), .o_dest_index(o_dest_index),
  .o_general_write(o_general_write), .o_general_result(o_general_result),
  .o_condition_write(o_condition_write), .o_condition_result(o_condition_result),
  .o_jump_hold(o_jump_hold));

// [testbench/cou_cond_model.sv]
`timescale 1ns/1ps
module cou_cond_model (
  input  wire       i_clock,
  input  wire       i_reset,
  input  wire       i_condition_write,
  input  wire [3:0] i_condition_result,
  input  wire       i_jump_hold,
  output wire       o_jump_ok,
  output wire [3:0] o_cond_now
);
  reg [3:0] cond_reg;
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) cond_reg <= 4'h0;
    else if (i_condition_write) cond_reg <= i_condition_result;
  end
  assign o_cond_now = i_condition_write ? i_condition_result : cond_reg;
  assign o_jump_ok = !i_jump_hold;
endmodule // cou_cond_model

// [testbench/test_cou_compare_unit.sv]
`timescale 1ns/1ps
`include "cou_defines.vh"
module test_cou_compare_unit;
  reg i_clock = 1'b0, i_reset = 1'b1, i_issue = 1'b0, i_dest_is_condition = 1'b0;
  reg i_use_immediate = 1'b0;
  reg [3:0] i_opcode = 4'h0;
  reg [5:0] i_dest_index = 6'h0;
  reg [31:0] i_first_operand = 32'h0, i_second_operand = 32'h0;
  reg [8:0] i_immediate_second_operand = 9'h0;
  wire o_result_valid, o_general_write, o_condition_write, o_jump_hold, jump_ok;
  wire [5:0] o_dest_index;
  wire [31:0] o_general_result;
  wire [3:0] o_condition_result, cond_now;
  integer error_cnt = 0, compares = 0, cycles = 0, op, c;
  always #20 i_clock = ~i_clock;
  cou_compare_unit u_cou_compare_unit (.i_clock(i_clock), .i_reset(i_reset), .i_issue(i_issue),
    .i_opcode(i_opcode), .i_dest_is_condition(i_dest_is_condition),
    .i_use_immediate(i_use_immediate), .i_dest_index(i_dest_index),
    .i_first_operand(i_first_operand), .i_second_operand(i_second_operand),
    .i_immediate_second_operand(i_immediate_second_operand), .o_result_valid(o_result_valid),
    .o_dest_index(o_dest_index), .o_general_write(o_general_write),
    .o_general_result(o_general_result), .o_condition_write(o_condition_write),
    .o_condition_result(o_condition_result), .o_jump_hold(o_jump_hold));
  cou_cond_model u_cou_cond_model (.i_clock(i_clock), .i_reset(i_reset),
    .i_condition_write(o_condition_write), .i_condition_result(o_condition_result),
    .i_jump_hold(o_jump_hold), .o_jump_ok(jump_ok), .o_cond_now(cond_now));
  // Reference: floats follow the unit's own order, any NaN gives 0
  function [31:0] ref_gen(input [3:0] o, input [31:0] a, input [31:0] b);
    reg nan, zz, g;
    begin
      nan = (a[30:23] == 8'hff && a[22:0] != 0) || (b[30:23] == 8'hff && b[22:0] != 0);
      zz = a[30:0] == 0 && b[30:0] == 0;
      g = zz ? 1'b1 : (a[31] != b[31]) ? !a[31] : a[31] ? a[30:0] <= b[30:0] : a[30:0] >= b[30:0];
      case (o)
        `COU_OP_EQ: ref_gen = {31'h0, a == b};
        `COU_OP_GE: ref_gen = {31'h0, $signed(a) >= $signed(b)};
        `COU_OP_GEU: ref_gen = {31'h0, a >= b};
        `COU_OP_GT: ref_gen = {31'h0, $signed(a) > $signed(b)};
        `COU_OP_PB_EQ: ref_gen = {7'h0, a[31:24] == b[31:24], 7'h0, a[23:16] == b[23:16],
          7'h0, a[15:8] == b[15:8], 7'h0, a[7:0] == b[7:0]};
        `COU_OP_PH_EQ: ref_gen = {15'h0, a[31:16] == b[31:16], 15'h0, a[15:0] == b[15:0]};
        `COU_OP_FEQ: ref_gen = {31'h0, (zz || a == b) && !nan};
        `COU_OP_FGE: ref_gen = {31'h0, g && !nan};
        default: ref_gen = 32'h0;
      endcase
    end
  endfunction
  task chk(input [8*8-1:0] name, input [31:0] e, input [31:0] s);
    begin
      compares = compares + 1;
      if (e !== s) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s expected %h seen %h", name, e, s);
      end
    end
  endtask
  task go(input [3:0] o, input cn, input im, input [31:0] a, input [31:0] b, input [8:0] iv);
    reg [31:0] bb, g;
    reg [3:0] ce;
    begin
      bb = (im && o < 4) ? (o == `COU_OP_GEU ? {23'h0, iv} : {{23{iv[8]}}, iv}) : b;
      g = ref_gen(o, a, bb);
      ce = (o == `COU_OP_PB_EQ) ? {g[24], g[16], g[8], g[0]} :
           (o == `COU_OP_PH_EQ) ? {g[16], g[16], g[0], g[0]} : {3'h0, g[0]};
      i_issue = 1'b1; i_opcode = o; i_dest_is_condition = cn; i_use_immediate = im;
      i_dest_index = i_dest_index + 6'h1; i_first_operand = a; i_second_operand = b;
      i_immediate_second_operand = iv;
      @(posedge i_clock); #1;
      chk("valid", 32'h1, {31'h0, o_result_valid});
      chk("dest", {26'h0, i_dest_index}, {26'h0, o_dest_index});
      chk("strobe", {30'h0, cn, !cn}, {30'h0, o_condition_write, o_general_write});
      if (cn) chk("cond", {28'h0, ce}, {28'h0, o_condition_result});
      else chk("general", g, o_general_result);
    end
  endtask
  task idle;
    begin i_issue = 1'b0; repeat (2) @(posedge i_clock); #1; end
  endtask
  task t_scalar;
    for (op = 0; op < 4; op = op + 1) for (c = 0; c < 2; c = c + 1) begin
      go(op, c, 0, 32'h5, 32'h5, 9'h0);
      go(op, c, 0, 32'hffffffff, 32'h1, 9'h0);
      go(op, c, 0, 32'h1, 32'hffffffff, 9'h0);
      go(op, c, 0, 32'h80000000, 32'h7fffffff, 9'h0);
    end
  endtask
  task t_imm;
    begin
      go(`COU_OP_EQ, 0, 1, 32'hffffff00, 32'h0, 9'h100);
      go(`COU_OP_GEU, 1, 1, 32'hff, 32'hffffffff, 9'h100);
      go(`COU_OP_GE, 0, 1, 32'hffffffff, 32'h0, 9'h1ff);
      go(`COU_OP_GT, 1, 1, 32'h0, 32'h5, 9'h1ff);
    end
  endtask
  task t_packed;
    for (c = 0; c < 2; c = c + 1) begin
      go(`COU_OP_PB_EQ, c, 1, 32'h12345678, 32'h12ff56ff, 9'h0);
      go(`COU_OP_PB_EQ, c, 0, 32'h00ff0080, 32'hff0000ff, 9'h0);
      go(`COU_OP_PH_EQ, c, 1, 32'h8000abcd, 32'h8000abce, 9'h0);
      go(`COU_OP_PH_EQ, c, 0, 32'h1234ffff, 32'h4321ffff, 9'h0);
    end
  endtask
  task t_float;
    for (op = 6; op < 8; op = op + 1) for (c = 0; c < 2; c = c + 1) begin
      go(op, c, 0, 32'h00000000, 32'h80000000, 9'h0);
      go(op, c, 0, 32'h7fc00000, 32'h7fc00000, 9'h0);
      go(op, c, 0, 32'h3f800000, 32'h40000000, 9'h0);
      go(op, c, 0, 32'hbf800000, 32'hc0000000, 9'h0);
      go(op, c, 0, 32'h7f800000, 32'h7f800000, 9'h0);
    end
  endtask
  task t_jump;
    begin
      go(`COU_OP_EQ, 1, 0, 32'h7, 32'h7, 9'h0);
      chk("jump1", 32'h0, {31'h0, jump_ok});
      chk("readnow", 32'h1, {28'h0, cond_now});
      go(`COU_OP_GT, 1, 0, 32'h1, 32'h2, 9'h0);
      chk("jumpbb", 32'h0, {31'h0, jump_ok});
      go(4'hf, 0, 0, 32'h1, 32'h1, 9'h0);
      chk("jump2", 32'h1, {31'h0, jump_ok});
      idle;
      chk("idle", 32'h0, {29'h0, o_result_valid, o_general_write, o_condition_write});
      chk("jump3", 32'h1, {31'h0, jump_ok});
    end
  endtask
  task test_done;
    begin
      $display("TB: errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Ceiling well above the 75 or so cycles the run needs
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge i_clock);
    #1 i_reset = 1'b0;
    t_scalar;
    t_imm;
    t_packed;
    t_float;
    t_jump;
    test_done;
  end
endmodule // test_cou_compare_unit
